// ===== core/pict_defines.vh
// register map, field positions, reset values and timing counts of the pwm/carrier timer
`ifndef PICT_DEFINES_VH
`define PICT_DEFINES_VH

`define PICT_OFF_MODE      8'h00
`define PICT_OFF_PERIOD    8'h04
`define PICT_OFF_DUTY      8'h08
`define PICT_OFF_CARRIER   8'h0c
`define PICT_OFF_STATUS    8'h10

`define PICT_MODE_ENABLE   0
`define PICT_MODE_CKS_LO   1
`define PICT_MODE_CKS_HI   3
`define PICT_MODE_CARRIER  4

`define PICT_CAR_ACTIVE    0
`define PICT_CAR_STAGING   1
`define PICT_CAR_REMOTE    2

`define PICT_ST_SEL        8
`define PICT_ST_OUT        9
`define PICT_ST_STROBE     10
`define PICT_ST_PEND       11

`define PICT_RST_MODE      8'h00
`define PICT_RST_CMP       8'h00
`define PICT_RST_CARRIER   3'h0

`define PICT_CKS_DIV1      3'h0
`define PICT_CKS_DIV2      3'h1
`define PICT_CKS_DIV4      3'h2
`define PICT_CKS_DIV16     3'h3
`define PICT_CKS_DIV64     3'h4
`define PICT_CKS_DIV1024   3'h5
`define PICT_CKS_DIV4096   3'h6

`define PICT_DUTY_AGE      3'h3
`define PICT_XFER_TICKS    2'h2

`endif

// ===== core/pict_prescale.v
// count clock prescaler: one-cycle tick at the selected division of pclk
module pict_prescale (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // selection and tick
  input  wire [2:0] cks,
  output reg        tick_q
);
`include "pict_defines.vh"

  reg  [11:0] div_q;
  reg  [11:0] mask;

  always @* begin
    case (cks)
      `PICT_CKS_DIV1:    mask = 12'h000;
      `PICT_CKS_DIV2:    mask = 12'h001;
      `PICT_CKS_DIV4:    mask = 12'h003;
      `PICT_CKS_DIV16:   mask = 12'h00f;
      `PICT_CKS_DIV64:   mask = 12'h03f;
      `PICT_CKS_DIV1024: mask = 12'h3ff;
      default:           mask = 12'hfff;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 12'h000;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_q + 12'h001;
      tick_q <= ((div_q & mask) == mask);
    end
  end

endmodule // pict_prescale

// ===== core/pict_xfer.v
// companion event synchroniser and staging-to-active transfer timing
module pict_xfer (
  // clock and reset
  input  wire pclk,
  input  wire presetn,
  // count clock tick and companion event
  input  wire tick,
  input  wire companion_counter_event,
  // synced strobe and transfer pulse
  output reg  synced_transfer_strobe,
  output reg  xfer_q
);
`include "pict_defines.vh"

  reg       s1_q;
  reg       s2_q;
  reg [1:0] stage_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q                   <= 1'b0;
      s2_q                   <= 1'b0;
      synced_transfer_strobe <= 1'b0;
      stage_q                <= 2'h0;
      xfer_q                 <= 1'b0;
    end else begin
      s1_q   <= companion_counter_event;
      s2_q   <= s1_q;
      xfer_q <= 1'b0;
      if (tick) begin
        synced_transfer_strobe <= s2_q;
        if (stage_q == `PICT_XFER_TICKS) begin
          xfer_q  <= 1'b1;
          stage_q <= 2'h0;
        end else if (stage_q != 2'h0) begin
          stage_q <= stage_q + 2'h1;
        end else if (s2_q && !synced_transfer_strobe) begin
          stage_q <= 2'h1;
        end
      end
    end
  end

endmodule // pict_xfer

// ===== core/pict_timer.v
// 8-bit pwm and infrared carrier timer channel with apb register access
// Overview of operation
// - period match clears, pulses irq, output active
// - duty match makes output inactive, no clear
// - period N+1 clocks, active M+1 clocks
// - first count clock masked, output inactive
// - disabling returns irq inactive, output too unless carrier mode with remote select clear
// - duty write latched while enabled, moves at first swap after three clocks
// - third channel output only enables event counter
// - carrier low and high widths from compares
// - select and active bit choose carrier output
// - staging bit writable, active bit read-only
// - companion event synced into transfer strobe
// - staging copied second count clock after strobe
// - enable clear stops and zeroes counter
// - carrier match inverts, clears, irq, alternates
// - falling active bit keeps full high width
// - carrier period N+M+2, high M+1 clocks
//
// Decided for this implementation: the APB register port and the placing of the registers.
module pict_timer #(
  parameter CARRIER_CAPABLE = 1,
  parameter THIRD_CHANNEL   = 0
) (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // companion event counter
  input  wire        companion_counter_event,
  // timer outputs
  output reg         timer_output,
  output reg         event_enable,
  output reg         channel_match_irq
);
`include "pict_defines.vh"

  localparam SEL_FIRST  = 1'b0;
  localparam SEL_SECOND = 1'b1;

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `PICT_OFF_MODE) || (a == `PICT_OFF_PERIOD) || (a == `PICT_OFF_DUTY) ||
                (a == `PICT_OFF_CARRIER) || (a == `PICT_OFF_STATUS);
    end
  endfunction

  // counter step shared by every mode
  function [7:0] bump;
    input [7:0] v;
    begin
      bump = v + 8'h01;
    end
  endfunction

  // compare hit against the register that the select bit points at
  function hit;
    input [7:0] c;
    input [7:0] v;
    input       s;
    input       want;
    begin
      hit = (s == want) && (c == v);
    end
  endfunction

  // pin level from mode, remote select, carrier level, gate and active bit
  function pin_level;
    input car;
    input rmc;
    input lvl;
    input gate;
    input nrz;
    begin
      if (!car) begin
        pin_level = lvl;
      end else if (rmc) begin
        pin_level = lvl && gate;
      end else begin
        pin_level = nrz;
      end
    end
  endfunction

  // software state
  reg        channel_enable_q;
  reg [2:0]  count_clock_select_q;
  reg        carrier_mode_q;
  reg [7:0]  period_compare_q;
  reg [7:0]  duty_compare_q;
  reg [7:0]  duty_latch_q;
  reg        duty_pend_q;
  reg [2:0]  duty_age_q;
  reg        remote_output_select_q;
  reg        carrier_enable_staging_q;
  reg        carrier_enable_active_q;
  // counting state
  reg [7:0]  cnt_q;
  reg        sel_q;
  reg        mask_q;
  reg        level_q;
  reg        gate_q;
  // combinational next values
  reg [7:0]  cnt_d;
  reg        sel_d;
  reg        level_d;
  reg        gate_d;
  reg        irq_d;
  reg        out_d;
  reg        nrz_d;
  reg        swap;
  reg [31:0] rdata_d;

  wire       tick;
  wire       xfer;
  wire       strobe;
  wire       wr_en;
  wire       rd_go;
  wire [7:0] target;
  wire       duty_move;
  wire       age_run;

  assign wr_en  = psel && penable && pwrite && pready && addr_ok(paddr);
  assign rd_go  = psel && penable && !pready;
  assign target = (sel_q == SEL_FIRST) ? period_compare_q : duty_compare_q;
  assign duty_move = swap && duty_pend_q && (duty_age_q == `PICT_DUTY_AGE);
  assign age_run   = tick && (duty_age_q != `PICT_DUTY_AGE);

  pict_prescale u_prescale (
    .pclk    (pclk),
    .presetn (presetn),
    .cks     (count_clock_select_q),
    .tick_q  (tick)
  );

  pict_xfer u_xfer (
    .pclk                    (pclk),
    .presetn                 (presetn),
    .tick                    (tick),
    .companion_counter_event (companion_counter_event),
    .synced_transfer_strobe  (strobe),
    .xfer_q                  (xfer)
  );

  // counter, compare selection and output level
  always @* begin
    cnt_d   = cnt_q;
    sel_d   = sel_q;
    level_d = level_q;
    irq_d   = 1'b0;
    swap    = 1'b0;
    if (!channel_enable_q) begin
      cnt_d   = 8'h00;
      sel_d   = SEL_FIRST;
      level_d = 1'b0;
    end else if (tick && !mask_q) begin
      if (carrier_mode_q) begin
        if (cnt_q == target) begin
          cnt_d   = 8'h00;
          level_d = !level_q;
          irq_d   = 1'b1;
          sel_d   = !sel_q;
          swap    = (sel_q == SEL_SECOND);
        end else begin
          cnt_d = bump(cnt_q);
        end
      end else if (hit(cnt_q, period_compare_q, sel_q, SEL_FIRST)) begin
        cnt_d   = 8'h00;
        irq_d   = 1'b1;
        level_d = 1'b1;
        sel_d   = SEL_SECOND;
      end else if (hit(cnt_q, duty_compare_q, sel_q, SEL_SECOND)) begin
        cnt_d   = bump(cnt_q);
        level_d = 1'b0;
        sel_d   = SEL_FIRST;
        swap    = 1'b1;
      end else begin
        cnt_d = bump(cnt_q);
      end
    end
  end

  // carrier gating and pin level
  always @* begin
    nrz_d  = xfer ? carrier_enable_staging_q : carrier_enable_active_q;
    gate_d = gate_q;
    if (!level_d || !carrier_mode_q) begin
      gate_d = nrz_d;
    end
    out_d = pin_level(carrier_mode_q, remote_output_select_q, level_d, gate_d, nrz_d);
  end

  // read data
  always @* begin
    rdata_d = 32'h00000000;
    case (paddr)
      `PICT_OFF_MODE: begin
        rdata_d[`PICT_MODE_ENABLE]                    = channel_enable_q;
        rdata_d[`PICT_MODE_CKS_HI:`PICT_MODE_CKS_LO] = count_clock_select_q;
        rdata_d[`PICT_MODE_CARRIER]                   = carrier_mode_q;
      end
      `PICT_OFF_PERIOD: begin
        rdata_d[7:0] = period_compare_q;
      end
      `PICT_OFF_DUTY: begin
        rdata_d[7:0] = duty_pend_q ? duty_latch_q : duty_compare_q;
      end
      `PICT_OFF_CARRIER: begin
        rdata_d[`PICT_CAR_ACTIVE]  = carrier_enable_active_q;
        rdata_d[`PICT_CAR_STAGING] = carrier_enable_staging_q;
        rdata_d[`PICT_CAR_REMOTE]  = remote_output_select_q;
      end
      `PICT_OFF_STATUS: begin
        rdata_d[7:0]           = cnt_q;
        rdata_d[`PICT_ST_SEL]    = sel_q;
        rdata_d[`PICT_ST_OUT]    = level_q;
        rdata_d[`PICT_ST_STROBE] = strobe;
        rdata_d[`PICT_ST_PEND]   = duty_pend_q;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  // apb handshake: one wait state on every access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_go;
      pslverr <= rd_go && !addr_ok(paddr);
      if (rd_go && !pwrite) begin
        prdata <= rdata_d;
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // software registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_enable_q         <= 1'b0;
      count_clock_select_q     <= 3'h0;
      carrier_mode_q           <= 1'b0;
      period_compare_q         <= `PICT_RST_CMP;
      duty_compare_q           <= `PICT_RST_CMP;
      duty_latch_q             <= `PICT_RST_CMP;
      duty_pend_q              <= 1'b0;
      duty_age_q               <= 3'h0;
      remote_output_select_q   <= 1'b0;
      carrier_enable_staging_q <= 1'b0;
      carrier_enable_active_q  <= 1'b0;
    end else begin
      carrier_enable_active_q <= nrz_d;
      if (age_run) begin
        duty_age_q <= duty_age_q + 3'h1;
      end
      if (duty_move) begin
        duty_compare_q <= duty_latch_q;
        duty_pend_q    <= 1'b0;
      end
      if (wr_en) begin
        case (paddr)
          `PICT_OFF_MODE: begin
            channel_enable_q <= pwdata[`PICT_MODE_ENABLE];
            if (!channel_enable_q) begin
              count_clock_select_q <= pwdata[`PICT_MODE_CKS_HI:`PICT_MODE_CKS_LO];
              carrier_mode_q       <= pwdata[`PICT_MODE_CARRIER] && (CARRIER_CAPABLE != 0);
            end
          end
          `PICT_OFF_PERIOD: begin
            period_compare_q <= pwdata[7:0];
          end
          `PICT_OFF_DUTY: begin
            if (channel_enable_q) begin
              duty_latch_q <= pwdata[7:0];
              duty_pend_q  <= 1'b1;
              duty_age_q   <= 3'h0;
            end else begin
              duty_compare_q <= pwdata[7:0];
              duty_pend_q    <= 1'b0;
            end
          end
          `PICT_OFF_CARRIER: begin
            carrier_enable_staging_q <= pwdata[`PICT_CAR_STAGING];
            if (!channel_enable_q) begin
              remote_output_select_q <= pwdata[`PICT_CAR_REMOTE];
            end
          end
          default: begin
            channel_enable_q <= channel_enable_q;
          end
        endcase
      end
    end
  end

  // counting and outputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q             <= 8'h00;
      sel_q             <= SEL_FIRST;
      mask_q            <= 1'b1;
      level_q           <= 1'b0;
      gate_q            <= 1'b0;
      timer_output      <= 1'b0;
      event_enable      <= 1'b0;
      channel_match_irq <= 1'b0;
    end else begin
      cnt_q             <= cnt_d;
      sel_q             <= sel_d;
      level_q           <= level_d;
      gate_q            <= gate_d;
      channel_match_irq <= irq_d;
      if (!channel_enable_q) begin
        mask_q <= 1'b1;
      end else if (tick) begin
        mask_q <= 1'b0;
      end
      if (THIRD_CHANNEL != 0) begin
        timer_output <= 1'b0;
        event_enable <= out_d;
      end else begin
        timer_output <= out_d;
        event_enable <= 1'b0;
      end
    end
  end

endmodule // pict_timer

// ===== test/pict_timer_asserts.sv
// concurrent checks on the ports of the pwm and carrier timer
`include "pict_defines.vh"
module pict_timer_asserts #(
  parameter THIRD_CHANNEL = 0
) (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb slave
  input wire [7:0]  paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // companion event and outputs
  input wire        companion_counter_event,
  input wire        timer_output,
  input wire        event_enable,
  input wire        channel_match_irq
);
  reg       en_q, car_q, seen_q;
  reg [2:0] cks_q;
  reg [7:0] per_q;
  reg [8:0] gap_q;
  wire      wr = psel && penable && pready && pwrite && !pslverr;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of mode and period; mode bits other than enable are frozen while running
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q   <= 1'b0;
      car_q  <= 1'b0;
      cks_q  <= 3'h0;
      per_q  <= 8'h00;
      gap_q  <= 9'h000;
      seen_q <= 1'b0;
    end else begin
      if (wr && paddr == `PICT_OFF_MODE) begin
        en_q <= pwdata[`PICT_MODE_ENABLE];
        if (!en_q) begin
          car_q <= pwdata[`PICT_MODE_CARRIER];
          cks_q <= pwdata[`PICT_MODE_CKS_HI:`PICT_MODE_CKS_LO];
        end
      end
      if (wr && paddr == `PICT_OFF_PERIOD)
        per_q <= pwdata[7:0];
      gap_q  <= channel_match_irq ? 9'h001 : gap_q + {8'h00, gap_q != 9'h1ff};
      seen_q <= en_q && (seen_q || channel_match_irq);
    end
  end
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_slverr_with_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("pslverr outside an access answer");
  a_third_route: assert property ((THIRD_CHANNEL != 0) ? !timer_output : !event_enable)
    else $error("timer level routed to the wrong output");
  a_pwm_period: assert property (channel_match_irq && seen_q && !car_q && cks_q == 3'h0
    |-> gap_q == {1'b0, per_q} + 9'h001)
    else $error("pwm period not period compare plus one");
  a_irq_enabled: assert property (channel_match_irq |-> en_q || $past(en_q))
    else $error("match irq while channel disabled");
  a_start_inactive: assert property ($rose(en_q) && !car_q |-> !timer_output [*3])
    else $error("pwm output active right after enable");
  a_disable_quiet: assert property ((!en_q && !car_q) [*3] |-> !timer_output && !channel_match_irq)
    else $error("output or irq active while disabled");
endmodule // pict_timer_asserts

// ===== test/pict_pin_model.sv
// far side model: companion event source and pin width monitor
module pict_pin_model (
  // clock and trigger
  input  wire       pclk,
  input  wire       fire,
  // pin and companion event
  input  wire       pin,
  output reg        companion_counter_event,
  // last finished high and low widths in pclk cycles
  output reg  [8:0] hi_len,
  output reg  [8:0] lo_len
);
  reg [3:0] hold_q;
  reg [8:0] run_q;
  reg       last_q;
  initial begin
    hold_q = 4'h0;
    run_q = 9'h000;
    last_q = 1'b0;
    companion_counter_event = 1'b0;
  end
  always @(posedge pclk) begin
    hold_q <= fire ? 4'h6 : hold_q - {3'h0, hold_q != 4'h0};
    companion_counter_event <= fire || hold_q > 4'h1;
    if (pin !== last_q) begin
      if (last_q)
        hi_len <= run_q;
      else
        lo_len <= run_q;
      run_q <= 9'h001;
    end else
      run_q <= run_q + 9'h001;
    last_q <= pin;
  end
endmodule // pict_pin_model

// ===== test/pict_timer_tb.sv
// self-checking bench of the pwm and carrier timer
`include "pict_defines.vh"
module pict_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, fire, ev, tout, ev_en, irq, pready, pslverr;
  logic [7:0]  paddr, n, m;
  logic [31:0] pwdata, prdata;
  logic [8:0]  hi_len, lo_len;
  logic [32:0] expq[$];
  int          n_mismatch, checked, cyc;
  pict_timer #(.CARRIER_CAPABLE(1), .THIRD_CHANNEL(0)) dut_u (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .companion_counter_event(ev), .timer_output(tout),
    .event_enable(ev_en), .channel_match_irq(irq));
  pict_pin_model pin_u (.pclk(pclk), .fire(fire), .pin(tout), .companion_counter_event(ev),
    .hi_len(hi_len), .lo_len(lo_len));
  task chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task fire_ev;
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
    @(posedge pclk);
  endtask
  // read answers are compared against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      chk({pslverr, prdata}, expq.pop_front());
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial begin
    void'($urandom(71));
    {presetn, psel, penable, pwrite, fire, paddr, pwdata} = '0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int a = 0; a < 24; a += 4) rd(a[7:0], {a == 20, 32'h0});
    wr(`PICT_OFF_CARRIER, 32'h1);
    rd(`PICT_OFF_CARRIER, 33'h0);
    n = 8'd4 + 8'($urandom % 12);
    m = 8'($urandom % n);
    wr(`PICT_OFF_PERIOD, n);
    wr(`PICT_OFF_DUTY, m);
    wr(`PICT_OFF_MODE, 32'h1);
    repeat (3) @(posedge irq);
    chk(hi_len, m + 1);
    chk(lo_len, n - m);
    m = 8'($urandom % n);
    wr(`PICT_OFF_DUTY, m);
    repeat (3) @(posedge irq);
    chk(hi_len, m + 1);
    rd(`PICT_OFF_DUTY, m);
    wr(`PICT_OFF_MODE, 32'h0);
    repeat (3) @(posedge pclk);
    chk(tout, 1'b0);
    rd(`PICT_OFF_STATUS, 33'h0);
    n = 8'd1 + 8'($urandom % 10);
    m = 8'd1 + 8'($urandom % 10);
    wr(`PICT_OFF_PERIOD, n);
    wr(`PICT_OFF_DUTY, m);
    wr(`PICT_OFF_CARRIER, 32'h6);
    wr(`PICT_OFF_MODE, 32'h11);
    fire_ev();
    repeat (8) @(posedge irq);
    chk(hi_len, m + 1);
    chk(lo_len, n + 1);
    rd(`PICT_OFF_CARRIER, 33'h7);
    wr(`PICT_OFF_CARRIER, 32'h4);
    fire_ev();
    repeat (8) @(posedge irq);
    chk(tout, 1'b0);
    chk(hi_len, m + 1);
    rd(`PICT_OFF_CARRIER, 33'h4);
    wr(`PICT_OFF_MODE, 32'h10);
    wr(`PICT_OFF_CARRIER, 32'h2);
    wr(`PICT_OFF_DUTY, m);
    wr(`PICT_OFF_MODE, 32'h11);
    fire_ev();
    repeat (3) @(posedge irq);
    chk(tout, 1'b1);
    end_sim();
  end
endmodule // pict_timer_tb
bind pict_timer pict_timer_asserts #(.THIRD_CHANNEL(THIRD_CHANNEL)) chk_u (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .companion_counter_event(companion_counter_event),
  .timer_output(timer_output), .event_enable(event_enable), .channel_match_irq(channel_match_irq));
